// >>> rtl/tbcr_defines.svh
`ifndef TBCR_DEFINES_SVH
`define TBCR_DEFINES_SVH

// device register byte offsets
`define TBCR_OFS_STATUS 12'h00c
`define TBCR_OFS_WPTR 12'h018
`define TBCR_OFS_TRIG_COUNT 12'h01c
`define TBCR_OFS_CAPTURE 12'h020
`define TBCR_OFS_TWD 12'h024
`define TBCR_OFS_MODE 12'h028
`define TBCR_OFS_LFILL 12'h02c
`define TBCR_OFS_CFILL 12'h030
`define TBCR_OFS_WMARK 12'h034
`define TBCR_OFS_FLUSH 12'h040
`define TBCR_OFS_FFS 12'h300

// device field positions
`define TBCR_CAPTURE_EN_BIT 0
`define TBCR_MODE_STALL_BIT 4
`define TBCR_FFS_FLUSH_BIT 0
`define TBCR_FFS_HALT_BIT 1
`define TBCR_STATUS_FULL_BIT 0
`define TBCR_STATUS_TRIG_BIT 1
`define TBCR_TRIG_COUNT_W 30
`define TBCR_TRIG_ID 7'h7d
`define TBCR_RST_WORD 32'h0000_0000

// trace source register byte offsets
`define TBCR_SRC_OFS_DATA 12'h000
`define TBCR_SRC_OFS_ID 12'h004
`define TBCR_SRC_OFS_TRIG 12'h008
`define TBCR_SRC_OFS_STAT 12'h00c
`define TBCR_SRC_PEND_BIT 0
`define TBCR_SRC_STALL_BIT 1
`define TBCR_SRC_FLUSH_BIT 2

`endif

// >>> rtl/tbcr_pkg.sv
package tbcr_pkg;

	typedef enum logic [1:0] {
		TBCR_MODE_CIRC = 2'h0,
		TBCR_MODE_SWFIFO = 2'h1,
		TBCR_MODE_HWFIFO = 2'h2,
		TBCR_MODE_RSVD = 2'h3
	} tbcr_mode_t;

	typedef enum logic [1:0] {
		TBCR_ST_DISABLED,
		TBCR_ST_RUNNING,
		TBCR_ST_STOPPED
	} tbcr_state_t;

	typedef enum logic {
		TBCR_SRC_IDLE,
		TBCR_SRC_SEND
	} tbcr_src_state_t;

endpackage : tbcr_pkg

// >>> rtl/tbcr_atb_if.sv
`timescale 1ns/10ps
interface tbcr_atb_if;
	logic atvalid;
	logic atready;
	logic [31:0] atdata;
	logic [6:0] atid;
	logic afvalid;
	logic afready;
	logic trigin;

	modport device (
		input atvalid,
		input atdata,
		input atid,
		input afready,
		input trigin,
		output atready,
		output afvalid
	);

	modport source (
		output atvalid,
		output atdata,
		output atid,
		output afready,
		output trigin,
		input atready,
		input afvalid
	);
endinterface : tbcr_atb_if

// >>> rtl/tbcr_source.sv
`timescale 1ns/10ps
`include "tbcr_defines.svh"
module tbcr_source (
	input wire logic clk_i, // system clock
	input wire logic rst_i, // sync reset, high
	tbcr_atb_if.source atb, // trace link toward the buffer
	input wire logic wb_cyc_i, // wishbone cycle
	input wire logic wb_stb_i, // wishbone strobe
	input wire logic wb_we_i, // wishbone write
	input wire logic [11:0] wb_adr_i, // byte address
	input wire logic [3:0] wb_sel_i, // byte selects
	input wire logic [31:0] wb_dat_i, // write data
	output logic [31:0] wb_dat_o, // read data
	output logic wb_ack_o // one-cycle ack
);

	tbcr_pkg::tbcr_src_state_t st_q, st_d;
	logic [31:0] data_q, data_d;
	logic [6:0] id_q, id_d;
	logic trig_q, trig_d;
	logic flush_q, flush_d;
	logic afr_q, afr_d;
	logic ack_q, ack_d;
	logic [31:0] rd_q, rd_d;
	logic req;

	////////////////////////////////////////////////////////////////////////////
	always_comb begin
		req = wb_cyc_i & wb_stb_i & ~ack_q;
		st_d = st_q;
		data_d = data_q;
		id_d = id_q;
		trig_d = trig_q;
		flush_d = flush_q;
		afr_d = atb.afvalid & ~afr_q;
		ack_d = req;
		rd_d = `TBCR_RST_WORD;
		unique case (st_q)
			tbcr_pkg::TBCR_SRC_IDLE: begin
				// a word written while one is pending is dropped
				if (req & wb_we_i & (wb_adr_i == `TBCR_SRC_OFS_DATA) & (&wb_sel_i)) begin
					data_d = wb_dat_i;
					st_d = tbcr_pkg::TBCR_SRC_SEND;
				end
			end
			tbcr_pkg::TBCR_SRC_SEND: begin
				if (atb.atready) begin
					st_d = tbcr_pkg::TBCR_SRC_IDLE;
				end
			end
		endcase
		if (req & wb_we_i & (wb_adr_i == `TBCR_SRC_OFS_ID) & wb_sel_i[0]) begin
			id_d = wb_dat_i[6:0];
		end
		if (req & wb_we_i & (wb_adr_i == `TBCR_SRC_OFS_TRIG) & wb_sel_i[0]) begin
			trig_d = wb_dat_i[0];
		end
		if (req & wb_we_i & (wb_adr_i == `TBCR_SRC_OFS_STAT) & wb_sel_i[0]
			& wb_dat_i[`TBCR_SRC_FLUSH_BIT]) begin
			flush_d = 1'b0;
		end
		// set beats clear
		if (atb.afvalid & afr_d) begin
			flush_d = 1'b1;
		end
		if (req & ~wb_we_i) begin
			unique case (wb_adr_i)
				`TBCR_SRC_OFS_DATA: rd_d = data_q;
				`TBCR_SRC_OFS_ID: rd_d = 32'(id_q);
				`TBCR_SRC_OFS_TRIG: rd_d = 32'(trig_q);
				`TBCR_SRC_OFS_STAT: begin
					rd_d[`TBCR_SRC_PEND_BIT] = (st_q == tbcr_pkg::TBCR_SRC_SEND);
					rd_d[`TBCR_SRC_STALL_BIT] = (st_q == tbcr_pkg::TBCR_SRC_SEND) & ~atb.atready;
					rd_d[`TBCR_SRC_FLUSH_BIT] = flush_q;
				end
				default: rd_d = `TBCR_RST_WORD;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_q <= tbcr_pkg::TBCR_SRC_IDLE;
			data_q <= `TBCR_RST_WORD;
			id_q <= 7'h00;
			trig_q <= 1'b0;
			flush_q <= 1'b0;
			afr_q <= 1'b0;
			ack_q <= 1'b0;
			rd_q <= `TBCR_RST_WORD;
		end else begin
			st_q <= st_d;
			data_q <= data_d;
			id_q <= id_d;
			trig_q <= trig_d;
			flush_q <= flush_d;
			afr_q <= afr_d;
			ack_q <= ack_d;
			rd_q <= rd_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	assign atb.atvalid = (st_q == tbcr_pkg::TBCR_SRC_SEND);
	assign atb.atdata = data_q;
	assign atb.atid = id_q;
	assign atb.afready = afr_q;
	assign atb.trigin = trig_q;
	assign wb_dat_o = rd_q;
	assign wb_ack_o = ack_q;

endmodule : tbcr_source

// >>> rtl/tbcr_device.sv
`timescale 1ns/10ps
`include "tbcr_defines.svh"
// Notes on behaviour
// (RULE_01) circular mode: trigger, count words, then event
// (RULE_02) software keeps trigger count frame aligned
// (RULE_03) trigger count is 30-bit read-write
// (RULE_04) control bit 0 enables capture, resets 0
// (RULE_05) test data writes only while disabled
// (RULE_06) test words packed into wide memory words
// (RULE_07) software changes mode only while disabled
// (RULE_08) mode field decodes three modes, ignored disabled
// (RULE_09) reserved mode runs software fifo, reads back
// (RULE_10) stall bit picks stall or discard after stop
// (RULE_11) latched level reports max, reloads on read
// (RULE_12) latched level frozen disabled, loaded on enable
// (RULE_13) fill levels are one plus log2 depth
// (RULE_14) current level tracks live, holds when disabled
// (RULE_15) fifo modes: full at depth minus watermark
// (RULE_16) watermark reads back, maximum depth minus one
// (RULE_17) software sets watermark while disabled only
// (RULE_18) circular mode: full when write pointer wraps
// (RULE_19) halted flag set on stop, cleared on enable
// (RULE_20) flush flag tracks flush, frozen while disabled
// (RULE_21) triggered flag set on event, cleared enable
// (RULE_22) unimplemented bits read zero, writes ignored
module tbcr_device #(
	parameter int unsigned MEM_DEPTH = 256, // trace memory size in 32-bit words
	parameter int unsigned MEM_WIDTH = 128 // memory word width, at least 64
) (
	input wire logic clk_i, // system clock
	input wire logic rst_i, // sync reset, high
	tbcr_atb_if.device atb, // trace link from the sources
	input wire logic wb_cyc_i, // wishbone cycle
	input wire logic wb_stb_i, // wishbone strobe
	input wire logic wb_we_i, // wishbone write
	input wire logic [11:0] wb_adr_i, // byte address
	input wire logic [3:0] wb_sel_i, // byte selects
	input wire logic [31:0] wb_dat_i, // write data
	output logic [31:0] wb_dat_o, // read data
	output logic wb_ack_o, // one-cycle ack
	output logic full_o // vacancy threshold reached in fifo modes, write pointer wrapped in circular mode
);

	localparam int unsigned LW = $clog2(MEM_DEPTH);
	localparam int unsigned LANES = MEM_WIDTH / 32;
	localparam int unsigned LB = $clog2(LANES);
	localparam logic [LW:0] DEPTH = (LW + 1)'(MEM_DEPTH);

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction : merge

	logic [MEM_WIDTH-1:0] mem [MEM_DEPTH/LANES];
	tbcr_pkg::tbcr_state_t st_q, st_d;
	logic [`TBCR_TRIG_COUNT_W-1:0] tcount_q, tcount_d, left_q, left_d;
	logic [1:0] mode_q, mode_d;
	logic stall_q, stall_d, armed_q, armed_d, trigd_q, trigd_d;
	logic full_q, full_d, halt_q, halt_d, fls_q, fls_d, afv_q, afv_d;
	logic rdy_q, rdy_d, ack_q, ack_d;
	logic [LW-1:0] ptr_q, ptr_d, wm_q, wm_d;
	logic [LW:0] fill_q, fill_d, lat_q, lat_d;
	logic [MEM_WIDTH-1:0] stg_q, stg_d;
	logic [31:0] rd_q, rd_d, wword, tmp;
	logic [2:0] tsync_q;
	logic req, wr, rd, take, store, twr, wmem, trig_seen, circ;
	tbcr_pkg::tbcr_mode_t emode;

	////////////////////////////////////////////////////////////////////////////
	always_comb begin
		req = wb_cyc_i & wb_stb_i & ~ack_q;
		wr = req & wb_we_i;
		rd = req & ~wb_we_i;
		tmp = `TBCR_RST_WORD;
		// reserved code runs as the software fifo
		emode = (mode_q == 2'h3) ? tbcr_pkg::TBCR_MODE_SWFIFO : tbcr_pkg::tbcr_mode_t'(mode_q); // [RULE_08] [RULE_09]
		circ = (emode == tbcr_pkg::TBCR_MODE_CIRC);
		take = atb.atvalid & rdy_q & (st_q == tbcr_pkg::TBCR_ST_RUNNING);
		// trigger packets are markers and are not stored
		store = take & (atb.atid != `TBCR_TRIG_ID);
		twr = wr & (wb_adr_i == `TBCR_OFS_TWD) & (st_q == tbcr_pkg::TBCR_ST_DISABLED); // [RULE_05]
		wword = store ? atb.atdata : wb_dat_i;
		wmem = (store | twr) & (ptr_q[LB-1:0] == LB'(LANES - 1)); // [RULE_06]
		trig_seen = (tsync_q[1] & ~tsync_q[2]) | (take & (atb.atid == `TBCR_TRIG_ID));
		st_d = st_q;
		tcount_d = tcount_q;
		left_d = left_q;
		mode_d = mode_q;
		stall_d = stall_q;
		armed_d = armed_q;
		trigd_d = trigd_q;
		full_d = full_q;
		halt_d = halt_q;
		fls_d = fls_q;
		afv_d = afv_q;
		ptr_d = ptr_q;
		wm_d = wm_q;
		fill_d = fill_q;
		lat_d = lat_q;
		stg_d = stg_q;
		ack_d = req;
		rd_d = `TBCR_RST_WORD;
		if (store | twr) begin
			stg_d[ptr_q[LB-1:0]*32 +: 32] = wword; // [RULE_06]
			ptr_d = ptr_q + LW'(1);
		end
		if (store) begin
			if (fill_q != DEPTH) begin
				fill_d = fill_q + (LW + 1)'(1); // [RULE_14]
			end
			if (circ & (ptr_q == LW'(MEM_DEPTH - 1))) begin
				full_d = 1'b1; // [RULE_18]
			end
		end
		if (~circ & (st_q != tbcr_pkg::TBCR_ST_DISABLED)) begin
			full_d = (fill_d >= (DEPTH - (LW + 1)'(wm_q))); // [RULE_15] [RULE_16]
		end
		unique case (st_q)
			tbcr_pkg::TBCR_ST_DISABLED: begin
				if (wr & (wb_adr_i == `TBCR_OFS_CAPTURE) & wb_sel_i[0]
					& wb_dat_i[`TBCR_CAPTURE_EN_BIT]) begin
					st_d = tbcr_pkg::TBCR_ST_RUNNING; // [RULE_04]
					trigd_d = 1'b0; // [RULE_21]
					full_d = 1'b0;
					halt_d = 1'b0; // [RULE_19]
					fls_d = 1'b0; // [RULE_20]
					armed_d = 1'b0;
					fill_d = '0;
					lat_d = '0; // [RULE_12]
				end
			end
			tbcr_pkg::TBCR_ST_RUNNING, tbcr_pkg::TBCR_ST_STOPPED: begin
				fls_d = afv_q; // [RULE_20]
				if (rd & (wb_adr_i == `TBCR_OFS_LFILL)) begin
					lat_d = fill_q; // [RULE_11]
				end else if (fill_d > lat_q) begin
					lat_d = fill_d; // [RULE_11]
				end
				if ((st_q == tbcr_pkg::TBCR_ST_RUNNING) & circ) begin
					if (armed_q & (left_q == '0)) begin
						armed_d = 1'b0;
						trigd_d = 1'b1; // [RULE_01] [RULE_21]
						halt_d = 1'b1; // [RULE_19]
						st_d = tbcr_pkg::TBCR_ST_STOPPED;
					end else if (armed_q & store) begin
						left_d = left_q - `TBCR_TRIG_COUNT_W'(1); // [RULE_01]
					end else if (~armed_q & ~trigd_q & trig_seen) begin
						armed_d = 1'b1; // [RULE_01]
						left_d = tcount_q;
					end
				end
				if (wr & (wb_adr_i == `TBCR_OFS_CAPTURE) & wb_sel_i[0]
					& ~wb_dat_i[`TBCR_CAPTURE_EN_BIT]) begin
					st_d = tbcr_pkg::TBCR_ST_DISABLED; // [RULE_04]
				end
			end
			default: st_d = tbcr_pkg::TBCR_ST_DISABLED;
		endcase
		if (afv_q & atb.afready) begin
			afv_d = 1'b0;
		end
		// stop leaves the link stalled only as the stall bit says; disable always stalls it
		rdy_d = (st_d == tbcr_pkg::TBCR_ST_RUNNING) | ((st_d == tbcr_pkg::TBCR_ST_STOPPED) & ~stall_q); // [RULE_10]
		if (wr) begin
			unique case (wb_adr_i)
				`TBCR_OFS_TRIG_COUNT: begin
					tmp = merge(32'(tcount_q), wb_dat_i, wb_sel_i);
					tcount_d = tmp[`TBCR_TRIG_COUNT_W-1:0]; // [RULE_03] [RULE_02]
				end
				`TBCR_OFS_MODE: begin
					// [RULE_07] mode is only changed while disabled by software
					tmp = merge({27'h0, stall_q, 2'h0, mode_q}, wb_dat_i, wb_sel_i);
					mode_d = tmp[1:0];
					stall_d = tmp[`TBCR_MODE_STALL_BIT]; // [RULE_22]
				end
				`TBCR_OFS_WPTR: begin
					tmp = merge({{(30 - LW){1'b0}}, ptr_q, 2'h0}, wb_dat_i, wb_sel_i);
					ptr_d = tmp[LW+1:2];
				end
				`TBCR_OFS_WMARK: begin
					// [RULE_17] watermark is set before enabling
					tmp = merge(32'(wm_q), wb_dat_i, wb_sel_i);
					wm_d = tmp[LW-1:0]; // [RULE_16]
				end
				`TBCR_OFS_FLUSH: begin
					if (wb_sel_i[0] & wb_dat_i[0] & (st_q != tbcr_pkg::TBCR_ST_DISABLED)) begin
						afv_d = 1'b1;
					end
				end
				default: tmp = `TBCR_RST_WORD;
			endcase
		end
		if (rd) begin
			unique case (wb_adr_i)
				`TBCR_OFS_STATUS: rd_d = {30'h0, trigd_q, full_q};
				`TBCR_OFS_WPTR: rd_d = {{(30 - LW){1'b0}}, ptr_q, 2'h0};
				`TBCR_OFS_TRIG_COUNT: rd_d = 32'(tcount_q); // [RULE_03]
				`TBCR_OFS_CAPTURE: rd_d = 32'(st_q != tbcr_pkg::TBCR_ST_DISABLED);
				`TBCR_OFS_MODE: rd_d = {27'h0, stall_q, 2'h0, mode_q}; // [RULE_09]
				`TBCR_OFS_LFILL: rd_d = 32'(lat_q); // [RULE_13]
				`TBCR_OFS_CFILL: rd_d = 32'(fill_q); // [RULE_13]
				`TBCR_OFS_WMARK: rd_d = 32'(wm_q);
				`TBCR_OFS_FLUSH: rd_d = 32'(afv_q);
				`TBCR_OFS_FFS: rd_d = {30'h0, halt_q, fls_q};
				default: rd_d = `TBCR_RST_WORD; // [RULE_22]
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_q <= tbcr_pkg::TBCR_ST_DISABLED;
			tcount_q <= '0;
			left_q <= '0;
			mode_q <= 2'h0;
			stall_q <= 1'b0;
			armed_q <= 1'b0;
			trigd_q <= 1'b0;
			full_q <= 1'b0;
			halt_q <= 1'b0;
			fls_q <= 1'b0;
			afv_q <= 1'b0;
			rdy_q <= 1'b0;
			ack_q <= 1'b0;
			ptr_q <= '0;
			wm_q <= '0;
			fill_q <= '0;
			lat_q <= '0;
			stg_q <= '0;
			rd_q <= `TBCR_RST_WORD;
			tsync_q <= 3'h0;
		end else begin
			st_q <= st_d;
			tcount_q <= tcount_d;
			left_q <= left_d;
			mode_q <= mode_d;
			stall_q <= stall_d;
			armed_q <= armed_d;
			trigd_q <= trigd_d;
			full_q <= full_d;
			halt_q <= halt_d;
			fls_q <= fls_d;
			afv_q <= afv_d;
			rdy_q <= rdy_d;
			ack_q <= ack_d;
			ptr_q <= ptr_d;
			wm_q <= wm_d;
			fill_q <= fill_d;
			lat_q <= lat_d;
			stg_q <= stg_d;
			rd_q <= rd_d;
			// trigger pin: two stages, then an edge stage
			tsync_q <= {tsync_q[1:0], atb.trigin};
		end
	end

	// no reset on the array; contents are only meaningful once written
	always_ff @(posedge clk_i) begin
		if (wmem) begin
			mem[ptr_q[LW-1:LB]] <= stg_d; // [RULE_06]
		end
	end

	////////////////////////////////////////////////////////////////////////////
	assign atb.atready = rdy_q;
	assign atb.afvalid = afv_q;
	assign wb_dat_o = rd_q;
	assign wb_ack_o = ack_q;
	assign full_o = full_q;

endmodule : tbcr_device

// >>> sim/tbcr_link_assertions.sv
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
module tbcr_link_assertions (
	input wire logic clk_i, // system clock
	input wire logic rst_i, // sync reset, high
	input wire logic atvalid, // word offered
	input wire logic atready, // word accepted
	input wire logic [31:0] atdata, // trace word
	input wire logic [6:0] atid, // trace id
	input wire logic afvalid, // flush request
	input wire logic afready, // flush done
	input wire logic trigin // trigger pin
);
	default clocking link_clk @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	// request, one answer pulse, then the request drops
	sequence s_flush_ack;
		##[1:8] afready ##1 !afvalid;
	endsequence

	a_reset_quiet: assert property ($fell(rst_i) |-> !atready && !afvalid && !atvalid)
		else $error("link busy right after reset");
	// a trigger pin high out of reset would look like a false edge
	a_trig_idle: assert property ($fell(rst_i) |-> !trigin && !afready)
		else $error("trigger or flush answer high right after reset");
	a_word_hold: assert property (atvalid && !atready |=> atvalid && $stable(atdata) && $stable(atid))
		else $error("offered word changed while stalled");
	a_word_once: assert property (atvalid && atready |=> !atvalid)
		else $error("word offered again after capture");
	a_flush_hold: assert property (afvalid && !afready |=> afvalid)
		else $error("flush request dropped early");
	a_flush_done: assert property ($rose(afvalid) |-> s_flush_ack)
		else $error("flush handshake incomplete");
	a_flush_start: assert property ($rose(afvalid) |-> !afready)
		else $error("flush answered before request");
	a_answer_cause: assert property (afready |-> afvalid)
		else $error("flush answer without request");
	a_answer_pulse: assert property (afready |=> !afready)
		else $error("flush answer longer than one cycle");
endmodule : tbcr_link_assertions

// >>> sim/tbcr_bench.sv
`timescale 1ns/10ps
`include "tbcr_defines.svh"
////////////////////////////////////////////////////////////////////////////////
module tbcr_bench;
	localparam int DEPTH = 16;
	localparam int DEV = 0;
	localparam int SRC = 1;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [1:0] wb_cyc = 2'h0;
	logic [1:0] wb_stb = 2'h0;
	logic wb_we = 1'b0;
	logic [11:0] wb_adr = 12'h000;
	logic [3:0] wb_sel = 4'hf;
	logic [31:0] wb_wdat = 32'h0;
	wire logic [31:0] wb_rdat [2];
	wire logic [1:0] wb_ack;
	logic full;
	int error_cnt = 0;
	int compares = 0;

	tbcr_atb_if atb ();

	always #5 clk_i = ~clk_i;

	tbcr_device #(.MEM_DEPTH(DEPTH), .MEM_WIDTH(128)) u_tbcr_device (.clk_i(clk_i), .rst_i(rst_i),
		.atb(atb), .wb_cyc_i(wb_cyc[0]), .wb_stb_i(wb_stb[0]), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
		.wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat[0]), .wb_ack_o(wb_ack[0]),
		.full_o(full));
	tbcr_source u_tbcr_source (.clk_i(clk_i), .rst_i(rst_i), .atb(atb), .wb_cyc_i(wb_cyc[1]),
		.wb_stb_i(wb_stb[1]), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
		.wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat[1]), .wb_ack_o(wb_ack[1]));
	tbcr_link_assertions u_tbcr_link_assertions (.clk_i(clk_i), .rst_i(rst_i),
		.atvalid(atb.atvalid), .atready(atb.atready), .atdata(atb.atdata), .atid(atb.atid),
		.afvalid(atb.afvalid), .afready(atb.afready), .trigin(atb.trigin));

	////////////////////////////////////////////////////////////////////////////
	task automatic test_done();
		if (error_cnt == 0 && compares > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : test_done

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// entered just after an edge; holds the request until ack is sampled
	task automatic wb(input int t, input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		wb_cyc[t] <= 1'b1;
		wb_stb[t] <= 1'b1;
		wb_we <= w;
		wb_adr <= a;
		wb_wdat <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack[t] !== 1'b1 && n < 50);
		if (n >= 50) begin
			error_cnt++;
			$display("MISMATCH %0t bus timeout", $time);
			test_done();
		end
		q = wb_rdat[t];
		wb_cyc[t] <= 1'b0;
		wb_stb[t] <= 1'b0;
		wb_we <= 1'b0;
		@(posedge clk_i);
	endtask : wb

	task automatic wr(input int t, input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		wb(t, 1'b1, a, d, q);
	endtask : wr

	task automatic rd(input int t, input logic [11:0] a, input logic [31:0] e);
		logic [31:0] q;
		wb(t, 1'b0, a, 32'h0, q);
		chk(q, e);
	endtask : rd

	task automatic poll(input int t, input logic [11:0] a, input logic [31:0] m,
		input logic [31:0] v);
		logic [31:0] q;
		int n;
		n = 0;
		do begin
			wb(t, 1'b0, a, 32'h0, q);
			n++;
		end while ((q & m) !== v && n < 40);
		chk(q & m, v);
		// only a poll that never matched ends the run
		if ((q & m) !== v) test_done();
	endtask : poll

	// one word through the source's single holding register
	task automatic send(input logic [31:0] d);
		wr(SRC, `TBCR_SRC_OFS_DATA, d);
		poll(SRC, `TBCR_SRC_OFS_STAT, 32'h1, 32'h0);
	endtask : send

	////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		rd(DEV, `TBCR_OFS_CAPTURE, 32'h0);
		rd(DEV, `TBCR_OFS_MODE, 32'h0);
		rd(DEV, `TBCR_OFS_FFS, 32'h0);
		rd(DEV, 12'h100, 32'h0);
		wr(DEV, `TBCR_OFS_TRIG_COUNT, 32'hffff_ffff);
		rd(DEV, `TBCR_OFS_TRIG_COUNT, 32'h3fff_ffff);
		wr(DEV, `TBCR_OFS_WMARK, 32'hffff_ffff);
		rd(DEV, `TBCR_OFS_WMARK, DEPTH - 1);
		for (int m = 0; m < 4; m++) begin
			wr(DEV, `TBCR_OFS_MODE, 32'hffff_ffe0 | m);
			rd(DEV, `TBCR_OFS_MODE, m);
		end
		wr(DEV, `TBCR_OFS_WPTR, 32'h0);
		for (int i = 0; i < 4; i++) wr(DEV, `TBCR_OFS_TWD, 32'h1111_1111 * i);
		rd(DEV, `TBCR_OFS_WPTR, 32'h10);
		// reserved mode still selected: must run as software fifo
		wr(DEV, `TBCR_OFS_CAPTURE, 32'h1);
		rd(DEV, `TBCR_OFS_CAPTURE, 32'h1);
		wr(DEV, `TBCR_OFS_TWD, 32'h5);
		rd(DEV, `TBCR_OFS_WPTR, 32'h10);
		chk({31'h0, full}, 32'h0);
		wr(SRC, `TBCR_SRC_OFS_ID, 32'h1);
		send(32'h1234_5678);
		chk({31'h0, full}, 32'h1);
		rd(DEV, `TBCR_OFS_STATUS, 32'h1);
		rd(DEV, `TBCR_OFS_CFILL, 32'h1);
		rd(DEV, `TBCR_OFS_LFILL, 32'h1);
		wr(DEV, `TBCR_OFS_CAPTURE, 32'h0);
		rd(DEV, `TBCR_OFS_CFILL, 32'h1);
		rd(DEV, `TBCR_OFS_LFILL, 32'h1);
		wr(DEV, `TBCR_OFS_MODE, 32'h10);
		rd(DEV, `TBCR_OFS_MODE, 32'h10);
		wr(DEV, `TBCR_OFS_TRIG_COUNT, 32'h4);
		wr(DEV, `TBCR_OFS_CAPTURE, 32'h1);
		rd(DEV, `TBCR_OFS_CFILL, 32'h0);
		rd(DEV, `TBCR_OFS_LFILL, 32'h0);
		wr(DEV, `TBCR_OFS_FLUSH, 32'h1);
		poll(SRC, `TBCR_SRC_OFS_STAT, 32'h4, 32'h4);
		rd(DEV, `TBCR_OFS_FFS, 32'h0);
		wr(SRC, `TBCR_SRC_OFS_ID, {25'h0, `TBCR_TRIG_ID});
		send(32'h0);
		wr(SRC, `TBCR_SRC_OFS_ID, 32'h1);
		for (int i = 0; i < 3; i++) send(32'ha0 + i);
		rd(DEV, `TBCR_OFS_STATUS, 32'h0);
		send(32'ha3);
		rd(DEV, `TBCR_OFS_STATUS, 32'h2);
		rd(DEV, `TBCR_OFS_FFS, 32'h2);
		rd(DEV, `TBCR_OFS_CFILL, 32'h4);
		wr(SRC, `TBCR_SRC_OFS_DATA, 32'hbad);
		repeat (4) @(posedge clk_i);
		rd(SRC, `TBCR_SRC_OFS_STAT, 32'h7);
		rd(DEV, `TBCR_OFS_CFILL, 32'h4);
		wr(DEV, `TBCR_OFS_CAPTURE, 32'h0);
		rd(DEV, `TBCR_OFS_FFS, 32'h2);
		wr(DEV, `TBCR_OFS_MODE, 32'h0);
		wr(DEV, `TBCR_OFS_TRIG_COUNT, 32'h0);
		// the stalled word lands on the last location and wraps
		wr(DEV, `TBCR_OFS_WPTR, (DEPTH - 1) * 4);
		wr(DEV, `TBCR_OFS_CAPTURE, 32'h1);
		poll(SRC, `TBCR_SRC_OFS_STAT, 32'h1, 32'h0);
		chk({31'h0, full}, 32'h1);
		rd(DEV, `TBCR_OFS_STATUS, 32'h1);
		wr(SRC, `TBCR_SRC_OFS_TRIG, 32'h1);
		poll(DEV, `TBCR_OFS_STATUS, 32'h2, 32'h2);
		send(32'h77);
		rd(DEV, `TBCR_OFS_CFILL, 32'h1);
		test_done();
	end
endmodule : tbcr_bench
